/* hw/mscs_top.sv */
// system clock select: oscillator control, clock muxing, low-power gating
//
// Contract
// - fast RC feeds fast clock when selected; runs only while enabled.
// - fast RC frequency is 4, 8 or 12 MHz by a two-bit field.
// - slow crystal feeds slow clock when selected; runs only while enabled.
// - slow crystal clock unusable until its start-up delay has passed.
// - sleep or idle gates the system clock off, stopping the processor.
// - pin-share bit gives slow crystal pins to oscillator or I/O; pins stay with the oscillator while the slow crystal is enabled.
// - speed-up bit: 0 low-power mode, 1 speed-up mode.
// - slow crystal mode frozen while it is the system clock.
// - both crystal modes run; low-power only lengthens start-up.
// - slow RC feeds slow clock when slow-source select picks it.
// - selected slow clock also feeds watchdog, LCD and time base.
// - system clock is fast or slow clock by three-bit select field.
// - fast and slow source select bits pick each clock's oscillator.
// - select field also offers fast clock divided by 2 to 64.
// - each oscillator but the slow RC, which has no enable bit, starts when its enable bit is set.
// - slow RC stops in sleep while the watchdog is disabled.
// - clearing a fast enable stops it; fast clocks then unavailable.
// - select codes: 000 undivided, then /2../64, 111 slow clock.
// - halt with both keep bits low sleeps; others pick idle states.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps

module mscs_top
  import mscs_pkg::*;
#(
  parameter int START_CYC = SLOW_XTAL_START_CYC
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    halt_req,
  input  wire logic                    wake_req,
  input  wire logic                    wdt_enable,
  input  wire mscs_pkg::mscs_osc_clk_s osc_clk,
  output mscs_pkg::mscs_osc_ctl_s      osc_ctl,
  output mscs_pkg::mscs_clk_out_s      clk_out
);
  import mscs_pkg::*;

  // ------------------------------------------------------------
  // oscillator input synchronisers
  // ------------------------------------------------------------
  logic [3:0] osc_meta;
  logic [3:0] osc_sync;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_meta <= 4'h0;
      osc_sync <= 4'h0;
    end else begin
      osc_meta <= osc_clk;
      osc_sync <= osc_meta;
    end
  end

  logic s_fast_rc;
  logic s_fast_xtal;
  logic s_slow_xtal;
  logic s_slow_rc;
  assign {s_fast_rc, s_fast_xtal, s_slow_xtal, s_slow_rc} = osc_sync;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [2:0]  clk_sel;
  logic        fast_src;
  logic        slow_src;
  logic        idle_fast_keep;
  logic        idle_slow_keep;
  logic        fast_rc_en;
  logic [1:0]  fast_rc_freq;
  logic        fast_xtal_en;
  logic        slow_xtal_en;
  logic        slow_xtal_speedup;
  logic        xt_pin_osc;
  logic [2:0]  next_clk_sel;
  logic        next_fast_src;
  logic        next_slow_src;
  logic        next_idle_fast_keep;
  logic        next_idle_slow_keep;
  logic        next_fast_rc_en;
  logic [1:0]  next_fast_rc_freq;
  logic        next_fast_xtal_en;
  logic        next_slow_xtal_en;
  logic        next_slow_xtal_speedup;
  logic        next_xt_pin_osc;
  logic [31:0] next_prdata;
  logic        addr_hit;
  logic        wr_en;
  logic        mode_lock;
  logic [31:0] rd_mux;
  logic        xtal_ready;
  logic        sw_hold;
  logic [2:0]  sel_cur;
  mscs_pmode_e pmode;

  always_comb begin
    unique case (paddr)
      SYS_CLK_CTRL_OFS,
      FAST_RC_CTRL_OFS,
      FAST_XTAL_CTRL_OFS,
      SLOW_XTAL_CTRL_OFS,
      PIN_SHARE_CTRL_OFS,
      CLK_STATUS_OFS:     addr_hit = 1'b1;
      default:            addr_hit = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign wr_en   = psel & penable & pwrite & addr_hit;
  // crystal mode cannot move while it drives the system clock
  assign mode_lock = (clk_sel == SEL_SLOW) & slow_src;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      SYS_CLK_CTRL_OFS: begin
        rd_mux[SCS_SEL_LSB +: 3] = clk_sel;
        rd_mux[SCS_FAST_SRC]     = fast_src;
        rd_mux[SCS_SLOW_SRC]     = slow_src;
        rd_mux[SCS_IDLE_FAST]    = idle_fast_keep;
        rd_mux[SCS_IDLE_SLOW]    = idle_slow_keep;
      end
      FAST_RC_CTRL_OFS: begin
        rd_mux[RC_EN_BIT]        = fast_rc_en;
        rd_mux[RC_FREQ_LSB +: 2] = fast_rc_freq;
      end
      FAST_XTAL_CTRL_OFS: rd_mux[XTAL_EN_BIT] = fast_xtal_en;
      SLOW_XTAL_CTRL_OFS: begin
        rd_mux[XTAL_EN_BIT]  = slow_xtal_en;
        rd_mux[XTAL_SPEEDUP] = slow_xtal_speedup;
        rd_mux[XTAL_READY]   = xtal_ready;
      end
      PIN_SHARE_CTRL_OFS: rd_mux[PIN_OSC_BIT] = xt_pin_osc;
      CLK_STATUS_OFS: begin
        rd_mux[4:0]            = pmode;
        rd_mux[ST_READY_BIT]   = xtal_ready;
        rd_mux[ST_SWITCH_BIT]  = sw_hold;
        rd_mux[ST_ON_SLOW_BIT] = (sel_cur == SEL_SLOW);
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_clk_sel           = clk_sel;
    next_fast_src          = fast_src;
    next_slow_src          = slow_src;
    next_idle_fast_keep    = idle_fast_keep;
    next_idle_slow_keep    = idle_slow_keep;
    next_fast_rc_en        = fast_rc_en;
    next_fast_rc_freq      = fast_rc_freq;
    next_fast_xtal_en      = fast_xtal_en;
    next_slow_xtal_en      = slow_xtal_en;
    next_slow_xtal_speedup = slow_xtal_speedup;
    next_xt_pin_osc        = xt_pin_osc;
    next_prdata            = prdata;
    // read data is latched in setup so it stands through the access phase
    if (psel & ~penable & ~pwrite) begin
      next_prdata = rd_mux;
    end
    if (wr_en) begin
      unique case (paddr)
        SYS_CLK_CTRL_OFS: begin
          next_clk_sel        = pwdata[SCS_SEL_LSB +: 3];
          next_fast_src       = pwdata[SCS_FAST_SRC];
          next_slow_src       = pwdata[SCS_SLOW_SRC];
          next_idle_fast_keep = pwdata[SCS_IDLE_FAST];
          next_idle_slow_keep = pwdata[SCS_IDLE_SLOW];
        end
        FAST_RC_CTRL_OFS: begin
          next_fast_rc_en = pwdata[RC_EN_BIT];
          // reserved code 11 leaves the frequency unchanged
          if (pwdata[RC_FREQ_LSB +: 2] != 2'h3) begin
            next_fast_rc_freq = pwdata[RC_FREQ_LSB +: 2];
          end
        end
        FAST_XTAL_CTRL_OFS: next_fast_xtal_en = pwdata[XTAL_EN_BIT];
        SLOW_XTAL_CTRL_OFS: begin
          next_slow_xtal_en = pwdata[XTAL_EN_BIT];
          if (!mode_lock) begin
            next_slow_xtal_speedup = pwdata[XTAL_SPEEDUP];
          end
        end
        PIN_SHARE_CTRL_OFS: next_xt_pin_osc = pwdata[PIN_OSC_BIT];
        default: next_prdata = prdata;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel           <= SEL_FAST_DIV1;
      fast_src          <= 1'b0;
      slow_src          <= 1'b0;
      idle_fast_keep    <= 1'b0;
      idle_slow_keep    <= 1'b0;
      fast_rc_en        <= FAST_RC_EN_RST;
      fast_rc_freq      <= FREQ_4MHZ;
      fast_xtal_en      <= 1'b0;
      slow_xtal_en      <= 1'b0;
      slow_xtal_speedup <= 1'b0;
      xt_pin_osc        <= 1'b0;
      prdata            <= 32'h0000_0000;
    end else begin
      clk_sel           <= next_clk_sel;
      fast_src          <= next_fast_src;
      slow_src          <= next_slow_src;
      idle_fast_keep    <= next_idle_fast_keep;
      idle_slow_keep    <= next_idle_slow_keep;
      fast_rc_en        <= next_fast_rc_en;
      fast_rc_freq      <= next_fast_rc_freq;
      fast_xtal_en      <= next_fast_xtal_en;
      slow_xtal_en      <= next_slow_xtal_en;
      slow_xtal_speedup <= next_slow_xtal_speedup;
      xt_pin_osc        <= next_xt_pin_osc;
      prdata            <= next_prdata;
    end
  end

  // ------------------------------------------------------------
  // power mode
  // ------------------------------------------------------------
  mscs_pmode_e next_pmode;

  always_comb begin
    next_pmode = pmode;
    unique case (pmode)
      PM_RUN: begin
        if (halt_req) begin
          unique case ({idle_fast_keep, idle_slow_keep})
            2'b00: next_pmode = PM_SLEEP;
            2'b01: next_pmode = PM_IDLE0;
            2'b11: next_pmode = PM_IDLE1;
            2'b10: next_pmode = PM_IDLE2;
          endcase
        end
      end
      PM_SLEEP, PM_IDLE0, PM_IDLE1, PM_IDLE2: begin
        if (wake_req) begin
          next_pmode = PM_RUN;
        end
      end
      default: next_pmode = PM_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pmode <= PM_RUN;
    end else begin
      pmode <= next_pmode;
    end
  end

  logic fast_mode_on;
  logic slow_mode_on;
  assign fast_mode_on = (pmode == PM_RUN) | (pmode == PM_IDLE1)
                      | (pmode == PM_IDLE2);
  // without a watchdog nothing needs the slow clock in these states
  assign slow_mode_on = ~(((pmode == PM_SLEEP) | (pmode == PM_IDLE2))
                          & ~wdt_enable);

  // ------------------------------------------------------------
  // slow crystal start-up
  // ------------------------------------------------------------
  logic [XTAL_CNT_W-1:0] xtal_cnt;
  logic [XTAL_CNT_W-1:0] next_xtal_cnt;
  logic [XTAL_CNT_W-1:0] xtal_limit;
  logic                  next_xtal_ready;

  // low-power mode only stretches the wait
  assign xtal_limit = slow_xtal_speedup ? XTAL_CNT_W'(START_CYC)
                    : XTAL_CNT_W'(START_CYC * SLOW_XTAL_LP_FACTOR);

  always_comb begin
    next_xtal_cnt   = xtal_cnt;
    next_xtal_ready = xtal_ready;
    if (!slow_xtal_en) begin
      next_xtal_cnt   = '0;
      next_xtal_ready = 1'b0;
    end else if (!xtal_ready) begin
      next_xtal_cnt = xtal_cnt + XTAL_CNT_W'(1);
      if (next_xtal_cnt >= xtal_limit) begin
        next_xtal_ready = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_cnt   <= '0;
      xtal_ready <= 1'b0;
    end else begin
      xtal_cnt   <= next_xtal_cnt;
      xtal_ready <= next_xtal_ready;
    end
  end

  // ------------------------------------------------------------
  // clock generation
  // ------------------------------------------------------------
  logic       fast_src_cur;
  logic       slow_src_cur;
  logic       fast_lvl_q;
  logic [5:0] div_cnt;
  logic       gate_cur;
  logic       next_fast_src_cur;
  logic       next_slow_src_cur;
  logic [5:0] next_div_cnt;
  logic [2:0] next_sel_cur;
  logic       next_sw_hold;
  logic       next_gate_cur;
  logic       fast_rc_lvl;
  logic       fast_xtal_lvl;
  logic       slow_xtal_lvl;
  logic       fast_lvl;
  logic       slow_lvl;
  logic       cur_lvl;
  mscs_clk_out_s next_clk_out;

  // a stopped oscillator contributes nothing downstream
  assign fast_rc_lvl   = s_fast_rc & fast_rc_en;
  assign fast_xtal_lvl = s_fast_xtal & fast_xtal_en;
  assign slow_xtal_lvl = s_slow_xtal & slow_xtal_en & xtal_ready;
  assign fast_lvl = fast_src_cur ? fast_xtal_lvl : fast_rc_lvl;
  assign slow_lvl = slow_src_cur ? slow_xtal_lvl : s_slow_rc;

  always_comb begin
    if (sel_cur == SEL_SLOW) begin
      cur_lvl = slow_lvl;
    end else if (sel_cur == SEL_FAST_DIV1) begin
      cur_lvl = fast_lvl;
    end else begin
      cur_lvl = div_cnt[sel_cur - 3'h1];
    end
  end

  always_comb begin
    next_fast_src_cur = fast_src_cur;
    next_slow_src_cur = slow_src_cur;
    next_sel_cur      = sel_cur;
    next_sw_hold      = sw_hold;
    next_gate_cur     = gate_cur;
    next_div_cnt      = div_cnt;
    // source swaps only while both candidates sit low and the old one
    // was low a cycle earlier too, so no low phase shrinks to one cycle
    if (~fast_rc_lvl & ~fast_xtal_lvl & ~fast_lvl_q) begin
      next_fast_src_cur = fast_src;
    end
    if (~slow_xtal_lvl & ~s_slow_rc & ~clk_out.slow_clk) begin
      next_slow_src_cur = slow_src;
    end
    if (fast_lvl & ~fast_lvl_q) begin
      next_div_cnt = div_cnt + 6'h01;
    end
    // leave old source at a low phase, join new one at a low phase
    if (!sw_hold && (clk_sel != sel_cur) && !clk_out.sys_clk
        && !cur_lvl) begin
      next_sel_cur = clk_sel;
      next_sw_hold = 1'b1;
    end else if (sw_hold && !cur_lvl) begin
      next_sw_hold = 1'b0;
    end
    // a rising source here would leave a one-cycle high pulse
    if (!clk_out.sys_clk && !cur_lvl) begin
      next_gate_cur = (pmode == PM_RUN);
    end
    next_clk_out.sys_clk         = gate_cur & ~sw_hold & cur_lvl;
    next_clk_out.fast_clk        = fast_lvl & fast_mode_on;
    next_clk_out.slow_clk        = slow_lvl;
    next_clk_out.periph_slow_clk = slow_lvl & slow_mode_on;
    next_clk_out.cpu_run         = (pmode == PM_RUN);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_src_cur <= 1'b0;
      slow_src_cur <= 1'b0;
      fast_lvl_q   <= 1'b0;
      div_cnt      <= 6'h00;
      sel_cur      <= SEL_FAST_DIV1;
      sw_hold      <= 1'b0;
      gate_cur     <= 1'b1;
      clk_out      <= '0;
    end else begin
      fast_src_cur <= next_fast_src_cur;
      slow_src_cur <= next_slow_src_cur;
      fast_lvl_q   <= fast_lvl;
      div_cnt      <= next_div_cnt;
      sel_cur      <= next_sel_cur;
      sw_hold      <= next_sw_hold;
      gate_cur     <= next_gate_cur;
      clk_out      <= next_clk_out;
    end
  end

  // ------------------------------------------------------------
  // oscillator enables and pin sharing
  // ------------------------------------------------------------
  always_comb begin
    osc_ctl.fast_rc_en        = fast_rc_en & fast_mode_on;
    osc_ctl.fast_rc_freq      = fast_rc_freq;
    osc_ctl.fast_xtal_en      = fast_xtal_en & fast_mode_on;
    osc_ctl.slow_xtal_en      = slow_xtal_en;
    osc_ctl.slow_xtal_speedup = slow_xtal_speedup;
    osc_ctl.slow_rc_en        = slow_mode_on;
    // pins stay with the crystal whenever it is in use
    osc_ctl.xt_pins_osc       = xt_pin_osc | slow_xtal_en;
  end

endmodule

/* hw/mscs_pkg.sv */
// package: constants, types and register map of the system clock select block
package mscs_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_FREQ_KHZ        = 20000;
  localparam int SLOW_XTAL_START_US  = 1000;
  localparam int SLOW_XTAL_START_CYC =
    (SLOW_XTAL_START_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int SLOW_XTAL_LP_FACTOR = 4;
  localparam int XTAL_CNT_W          = 18;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] SYS_CLK_CTRL_OFS   = 8'h00;
  localparam logic [7:0] FAST_RC_CTRL_OFS   = 8'h04;
  localparam logic [7:0] FAST_XTAL_CTRL_OFS = 8'h08;
  localparam logic [7:0] SLOW_XTAL_CTRL_OFS = 8'h0C;
  localparam logic [7:0] PIN_SHARE_CTRL_OFS = 8'h10;
  localparam logic [7:0] CLK_STATUS_OFS     = 8'h14;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SCS_SEL_LSB     = 5;
  localparam int SCS_FAST_SRC    = 3;
  localparam int SCS_SLOW_SRC    = 2;
  localparam int SCS_IDLE_FAST   = 1;
  localparam int SCS_IDLE_SLOW   = 0;
  localparam int RC_EN_BIT       = 0;
  localparam int RC_FREQ_LSB     = 1;
  localparam int XTAL_EN_BIT     = 0;
  localparam int XTAL_SPEEDUP    = 1;
  localparam int XTAL_READY      = 2;
  localparam int PIN_OSC_BIT     = 0;
  localparam int ST_READY_BIT    = 5;
  localparam int ST_SWITCH_BIT   = 6;
  localparam int ST_ON_SLOW_BIT  = 7;

  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [2:0] SEL_FAST_DIV1 = 3'h0;
  localparam logic [2:0] SEL_SLOW      = 3'h7;
  localparam logic [1:0] FREQ_4MHZ     = 2'h0;
  localparam logic [1:0] FREQ_8MHZ     = 2'h1;
  localparam logic [1:0] FREQ_12MHZ    = 2'h2;
  localparam logic       FAST_RC_EN_RST = 1'b1;

  typedef enum logic [4:0] {
    PM_RUN   = 5'h01,
    PM_SLEEP = 5'h02,
    PM_IDLE0 = 5'h04,
    PM_IDLE1 = 5'h08,
    PM_IDLE2 = 5'h10
  } mscs_pmode_e;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       fast_rc_en;
    logic [1:0] fast_rc_freq;
    logic       fast_xtal_en;
    logic       slow_xtal_en;
    logic       slow_xtal_speedup;
    logic       slow_rc_en;
    logic       xt_pins_osc;
  } mscs_osc_ctl_s;

  typedef struct packed {
    logic fast_rc;
    logic fast_xtal;
    logic slow_xtal;
    logic slow_rc;
  } mscs_osc_clk_s;

  typedef struct packed {
    logic sys_clk;
    logic fast_clk;
    logic slow_clk;
    logic periph_slow_clk;
    logic cpu_run;
  } mscs_clk_out_s;

endpackage

/* tb/mscs_top_chk.sv */
// checker: port assertions of the system clock select block
`timescale 1ns/100ps

module mscs_top_chk (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    halt_req,
  input wire logic                    wake_req,
  input wire logic                    wdt_enable,
  input wire mscs_pkg::mscs_osc_ctl_s osc_ctl,
  input wire mscs_pkg::mscs_clk_out_s clk_out
);
  import mscs_pkg::*;
  logic wr_c;
  assign wr_c = psel && penable && pwrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  apb_resp_a: assert property (
    psel && penable && paddr[1:0] == 2'h0
    |-> pready && pslverr == (paddr > 8'h14)) else $error("bad apb reply");
  err_idle_a: assert property (
    !(psel && penable) |-> !pslverr) else $error("stray slave error");
  freq_wr_a: assert property (
    wr_c && paddr == FAST_RC_CTRL_OFS |=> osc_ctl.fast_rc_freq ==
    ($past(pwdata[2:1]) == 2'h3 ? $past(osc_ctl.fast_rc_freq)
                                : $past(pwdata[2:1]))) else $error("freq");
  xen_wr_a: assert property (
    wr_c && paddr == SLOW_XTAL_CTRL_OFS
    |=> osc_ctl.slow_xtal_en == $past(pwdata[0])) else $error("xtal en");
  fxen_wr_a: assert property (
    wr_c && paddr == FAST_XTAL_CTRL_OFS && clk_out.cpu_run &&
    !halt_req && !$past(halt_req)
    |=> osc_ctl.fast_xtal_en == $past(pwdata[0])) else $error("fast en");
  pins_osc_a: assert property (
    osc_ctl.slow_xtal_en |-> osc_ctl.xt_pins_osc) else $error("pins");
  halt_stop_a: assert property (
    halt_req && clk_out.cpu_run ##1 !wake_req |=> !clk_out.cpu_run)
    else $error("halt ignored");
  wake_run_a: assert property (
    wake_req && !clk_out.cpu_run ##1 !halt_req |=> clk_out.cpu_run)
    else $error("wake ignored");
  sys_off_a: assert property (
    !clk_out.cpu_run && !clk_out.sys_clk && !wake_req && !$past(wake_req)
    |=> !clk_out.sys_clk) else $error("clock while halted");
  rc_keep_a: assert property (
    wdt_enable || clk_out.cpu_run && !$past(halt_req)
    |-> osc_ctl.slow_rc_en) else $error("slow rc stopped");
  no_glitch_a: assert property (
    $changed(clk_out.sys_clk) |=> $stable(clk_out.sys_clk))
    else $error("short clock phase");
endmodule

bind mscs_top mscs_top_chk i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .halt_req(halt_req), .wake_req(wake_req),
  .wdt_enable(wdt_enable), .osc_ctl(osc_ctl), .clk_out(clk_out)
);

/* tb/mscs_top_tb.sv */
// testbench: self-checking run of the system clock select block
`timescale 1ns/100ps

module mscs_top_tb;
  import mscs_pkg::*;
  localparam int SC = 20;
  // half periods: slow rc, slow xtal, fast xtal, fast rc
  localparam int HP [4] = '{50, 30, 6, 4};
  logic                    ref_clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [7:0]              paddr = 8'h00;
  logic [31:0]             pwdata = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    halt_req = 1'b0;
  logic                    wake_req = 1'b0;
  logic                    wdt_enable = 1'b0;
  logic [3:0]              ob = 4'h0;
  logic [3:0]              en;
  int                      oc [4] = '{0, 0, 0, 0};
  int                      mismatches = 0;
  int                      check_count = 0;
  int                      cyc = 0;
  mscs_osc_clk_s           osc_clk;
  mscs_osc_ctl_s           osc_ctl;
  mscs_clk_out_s           clk_out;

  mscs_top #(.START_CYC(SC)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
    .wake_req(wake_req), .wdt_enable(wdt_enable), .osc_clk(osc_clk),
    .osc_ctl(osc_ctl), .clk_out(clk_out)
  );

  // ----------------------------------------
  // oscillators, run only while enabled
  // ----------------------------------------
  always #25 ref_clk = ~ref_clk;
  assign en = {osc_ctl.fast_rc_en, osc_ctl.fast_xtal_en,
               osc_ctl.slow_xtal_en, osc_ctl.slow_rc_en};
  assign osc_clk = mscs_osc_clk_s'(ob);
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!en[i] || oc[i] == HP[i] - 1) begin
        oc[i] <= 0;
        ob[i] <= en[i] && !ob[i];
      end else begin
        oc[i] <= oc[i] + 1;
      end
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, got);
    check_count++;
    if (got !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // one apb transfer; released an edge later so tasks chain safely
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ex,
                     input string nm);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(nm, ex, r);
  endtask

  // cycles between the 2nd and 3rd rising edge of a clk_out bit
  task automatic per(input int b, input logic [31:0] ex, input string nm);
    int   c;
    int   r;
    int   t0;
    logic p;
    c = 0;
    r = 0;
    t0 = 0;
    p = 1'b1;
    while (r < 3 && c < 3000) begin
      @(posedge ref_clk);
      if (clk_out[b] === 1'b1 && p !== 1'b1) begin
        r++;
        if (r == 2) t0 = c;
      end
      p = clk_out[b];
      c++;
    end
    chk(nm, ex, 32'(c - 1 - t0));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 6; i++) begin
      rdc(8'(4 * i), (i == 1 || i == 5) ? 32'h1 : 32'h0, "reset");
    end
    xfer(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    chk("rc on", 32'h1, 32'(osc_ctl.fast_rc_en));
  endtask

  task automatic t_freq;
    for (int f = 0; f < 4; f++) begin
      wr(FAST_RC_CTRL_OFS, 32'(f * 2 + 1));
      chk("freq", (f == 3) ? 32'h2 : 32'(f), 32'(osc_ctl.fast_rc_freq));
    end
    wr(FAST_RC_CTRL_OFS, 32'h1);
  endtask

  task automatic t_div;
    for (int n = 0; n < 7; n++) begin
      wr(SYS_CLK_CTRL_OFS, 32'(n << SCS_SEL_LSB));
      per(4, 32'(8 << n), "divided");
    end
    per(3, 32'h8, "fast clk");
    wr(FAST_XTAL_CTRL_OFS, 32'h1);
    wr(SYS_CLK_CTRL_OFS, 32'h8);
    per(4, 32'hC, "fast xtal");
    wr(SYS_CLK_CTRL_OFS, 32'h0);
    wr(FAST_XTAL_CTRL_OFS, 32'h0);
    chk("xtal off", 32'h0, 32'(osc_ctl.fast_xtal_en));
  endtask

  task automatic t_slow;
    wr(SLOW_XTAL_CTRL_OFS, 32'h1);
    repeat (4 * SC - 12) @(posedge ref_clk);
    rdc(SLOW_XTAL_CTRL_OFS, 32'h1, "lp early");
    repeat (12) @(posedge ref_clk);
    rdc(SLOW_XTAL_CTRL_OFS, 32'h5, "lp ready");
    wr(SLOW_XTAL_CTRL_OFS, 32'h0);
    wr(SLOW_XTAL_CTRL_OFS, 32'h3);
    repeat (SC - 8) @(posedge ref_clk);
    rdc(SLOW_XTAL_CTRL_OFS, 32'h3, "sp early");
    repeat (10) @(posedge ref_clk);
    rdc(SLOW_XTAL_CTRL_OFS, 32'h7, "sp ready");
    wr(SYS_CLK_CTRL_OFS, 32'hE4);
    per(4, 32'h3C, "slow xtal");
    per(1, 32'h3C, "periph slow");
    per(2, 32'h3C, "slow clk");
    rdc(CLK_STATUS_OFS, 32'hA1, "on slow");
    wr(SLOW_XTAL_CTRL_OFS, 32'h1);
    rdc(SLOW_XTAL_CTRL_OFS, 32'h7, "mode frozen");
    wr(FAST_RC_CTRL_OFS, 32'h0);
    chk("rc stopped", 32'h0, 32'(osc_ctl.fast_rc_en));
    per(4, 32'h3C, "slow kept");
    wr(FAST_RC_CTRL_OFS, 32'h1);
    wr(SYS_CLK_CTRL_OFS, 32'hE0);
    per(4, 32'h64, "slow rc");
    wr(SYS_CLK_CTRL_OFS, 32'h0);
    wr(SLOW_XTAL_CTRL_OFS, 32'h0);
    chk("pins io", 32'h0, 32'(osc_ctl.xt_pins_osc));
    wr(PIN_SHARE_CTRL_OFS, 32'h1);
    chk("pins osc", 32'h1, 32'(osc_ctl.xt_pins_osc));
    wr(PIN_SHARE_CTRL_OFS, 32'h0);
  endtask

  task automatic t_lp;
    logic [1:0] k [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
    logic [4:0] m [5] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h02};
    logic [4:0] w = 5'b10000;
    logic [4:0] rc = 5'b10110;
    logic [4:0] fr = 5'b01100;
    for (int i = 0; i < 5; i++) begin
      wdt_enable <= w[i];
      wr(SYS_CLK_CTRL_OFS, 32'(k[i]));
      halt_req <= 1'b1;
      @(posedge ref_clk);
      halt_req <= 1'b0;
      repeat (12) @(posedge ref_clk);
      chk("cpu halted", 32'h0, 32'(clk_out.cpu_run));
      chk("sys gated", 32'h0, 32'(clk_out.sys_clk));
      chk("slow rc", 32'(rc[i]), 32'(osc_ctl.slow_rc_en));
      chk("fast rc", 32'(fr[i]), 32'(osc_ctl.fast_rc_en));
      rdc(CLK_STATUS_OFS, 32'(m[i]), "mode");
      wake_req <= 1'b1;
      @(posedge ref_clk);
      wake_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk("cpu woke", 32'h1, 32'(clk_out.cpu_run));
    end
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_freq();
    t_div();
    t_slow();
    t_lp();
    print_verdict();
  end
endmodule
